// File: rtl/hpp_port.sv
`default_nettype none
module hpp_port (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic host_chip_select_n, // Host chip select pin
  input wire logic read_strobe_n, // Separate-strobe read pin
  input wire logic write_strobe_n, // Separate-strobe write pin
  input wire logic single_data_strobe, // Single-strobe data strobe pin
  input wire logic direction_read_write_n, // Single-strobe direction, 1 = read
  input wire logic status_select, // Status byte select pin
  input wire logic byte_half_select, // Word half select pin, 1 = high half
  input wire logic [7:0] host_byte_bus_in, // Byte bus level from pins
  output logic [7:0] host_byte_bus_out, // Byte bus read data
  output logic host_byte_bus_oe, // Byte bus drive enable
  output logic output_empty_flag, // Output-empty flag pin
  output logic input_full_flag, // Input-full flag pin
  input wire logic mode_single_strobe, // 1 = single-strobe mode
  input wire logic strobe_active_high, // 1 = data strobe active high
  input wire logic empty_flag_invert, // Invert output-empty pin
  input wire logic full_flag_invert, // Invert input-full pin
  input wire logic out_word_load, // Processor loads output word
  input wire logic [15:0] out_word, // Word for host to read
  input wire logic in_word_take, // Processor consumed input word
  output logic [15:0] in_word, // Word written by host
  output logic out_buf_empty, // Output buffer empty
  output logic in_buf_full // Input buffer full
);
  localparam int unsigned BW = hpp_pkg::BYTE_W;
  localparam int unsigned WW = hpp_pkg::WORD_W;

  logic [hpp_pkg::SYNC_W-1:0] pins_s;
  logic cs_n_s, rd_n_s, wr_n_s, ds_s, dir_s, stat_s, bsel_s;
  logic [BW-1:0] data_s;

  hpp_sync #(
    .W(hpp_pkg::SYNC_W),
    .RST_VAL(hpp_pkg::SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({host_chip_select_n, read_strobe_n, write_strobe_n, single_data_strobe,
        direction_read_write_n, status_select, byte_half_select, host_byte_bus_in}),
    .q(pins_s)
  );

  assign {cs_n_s, rd_n_s, wr_n_s, ds_s, dir_s, stat_s, bsel_s, data_s} = pins_s;

  hpp_pkg::hpp_state_e state_q, state_d;
  logic stat_q, stat_d;
  logic bsel_q, bsel_d;
  logic empty_q, empty_d;
  logic full_q, full_d;
  logic empty_pin_q, empty_pin_d;
  logic full_pin_q, full_pin_d;
  logic [BW-1:0] rd_byte_q, rd_byte_d;
  logic [WW-1:0] out_buf_q, out_buf_d;
  logic [WW-1:0] in_buf_q, in_buf_d;
  logic ds_on, frame_on, rd_on, wr_on, start_rd, start_wr;
  logic [BW-1:0] status_byte;

  always_comb begin
    ds_on = strobe_active_high ? ds_s : ~ds_s;
    frame_on = ~cs_n_s & ds_on;
    rd_on = mode_single_strobe ? frame_on : (~cs_n_s & ~rd_n_s);
    wr_on = mode_single_strobe ? frame_on : (~cs_n_s & ~wr_n_s);
    // Direction is only sampled at the start, never used to frame
    start_rd = mode_single_strobe ? (frame_on & dir_s) : rd_on;
    start_wr = mode_single_strobe ? (frame_on & ~dir_s) : (wr_on & ~rd_on);
    status_byte = hpp_pkg::BYTE_RST;
    status_byte[hpp_pkg::STAT_EMPTY_BIT] = empty_q;
    status_byte[hpp_pkg::STAT_FULL_BIT] = full_q;
  end

  always_comb begin
    state_d = state_q;
    stat_d = stat_q;
    bsel_d = bsel_q;
    rd_byte_d = rd_byte_q;
    in_buf_d = in_buf_q;
    empty_d = empty_q;
    full_d = full_q;
    // Processor clear goes first so a high-half host write completing now still sets full
    if (in_word_take) begin
      full_d = 1'b0;
    end
    case (state_q)
      hpp_pkg::HPP_IDLE: begin
        if (start_rd || start_wr) begin
          stat_d = stat_s;
          bsel_d = bsel_s;
        end
        if (start_rd) begin
          state_d = hpp_pkg::HPP_READ;
          if (stat_s) begin
            rd_byte_d = status_byte;
          end else if (bsel_s == hpp_pkg::HALF_HIGH) begin
            rd_byte_d = out_buf_q[WW-1:BW];
          end else begin
            rd_byte_d = out_buf_q[BW-1:0];
          end
        end else if (start_wr) begin
          state_d = hpp_pkg::HPP_WRITE;
        end
      end
      hpp_pkg::HPP_READ: begin
        if (!rd_on) begin
          state_d = hpp_pkg::HPP_IDLE;
          if (!stat_q && bsel_q == hpp_pkg::HALF_HIGH) begin
            empty_d = 1'b1;
          end
        end
      end
      hpp_pkg::HPP_WRITE: begin
        if (!wr_on) begin
          state_d = hpp_pkg::HPP_IDLE;
          if (bsel_q == hpp_pkg::HALF_HIGH) begin
            in_buf_d[WW-1:BW] = data_s;
            full_d = 1'b1;
          end else begin
            in_buf_d[BW-1:0] = data_s;
          end
        end
      end
      default: begin
        state_d = hpp_pkg::HPP_IDLE;
      end
    endcase
    // A fresh processor word outranks a host read ending in the same cycle
    out_buf_d = out_word_load ? out_word : out_buf_q;
    if (out_word_load) begin
      empty_d = 1'b0;
    end
    empty_pin_d = empty_d ^ empty_flag_invert;
    full_pin_d = full_d ^ full_flag_invert;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= hpp_pkg::HPP_IDLE;
      stat_q <= 1'b0;
      bsel_q <= hpp_pkg::HALF_LOW;
      rd_byte_q <= hpp_pkg::BYTE_RST;
      out_buf_q <= hpp_pkg::WORD_RST;
      in_buf_q <= hpp_pkg::WORD_RST;
      empty_q <= hpp_pkg::EMPTY_RST;
      full_q <= hpp_pkg::FULL_RST;
      empty_pin_q <= hpp_pkg::EMPTY_RST;
      full_pin_q <= hpp_pkg::FULL_RST;
    end else begin
      state_q <= state_d;
      stat_q <= stat_d;
      bsel_q <= bsel_d;
      rd_byte_q <= rd_byte_d;
      out_buf_q <= out_buf_d;
      in_buf_q <= in_buf_d;
      empty_q <= empty_d;
      full_q <= full_d;
      empty_pin_q <= empty_pin_d;
      full_pin_q <= full_pin_d;
    end
  end

  assign host_byte_bus_out = rd_byte_q;
  assign host_byte_bus_oe = (state_q == hpp_pkg::HPP_READ);
  assign output_empty_flag = empty_pin_q;
  assign input_full_flag = full_pin_q;
  assign in_word = in_buf_q;
  assign out_buf_empty = empty_q;
  assign in_buf_full = full_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_read_begin: assert property ((state_q == hpp_pkg::HPP_IDLE) && !mode_single_strobe
    && !cs_n_s && !rd_n_s |=> state_q == hpp_pkg::HPP_READ && host_byte_bus_oe)
    else $error("separate read did not begin");
  a_write_begin: assert property ((state_q == hpp_pkg::HPP_IDLE) && !mode_single_strobe
    && !cs_n_s && !wr_n_s && rd_n_s |=> state_q == hpp_pkg::HPP_WRITE)
    else $error("separate write did not begin");
  a_single_begin: assert property ((state_q == hpp_pkg::HPP_IDLE) && mode_single_strobe
    && frame_on |=> (state_q == hpp_pkg::HPP_READ) == $past(dir_s)
    && state_q != hpp_pkg::HPP_IDLE)
    else $error("single strobe transaction direction wrong");
  a_strobe_level: assert property ((state_q == hpp_pkg::HPP_IDLE) && mode_single_strobe
    && (ds_s != strobe_active_high) |=> state_q == hpp_pkg::HPP_IDLE)
    else $error("inactive data strobe started a transaction");
  a_empty_update: assert property ((state_q == hpp_pkg::HPP_READ) && !rd_on && !stat_q
    && bsel_q && !out_word_load |=> output_empty_flag == ~$past(empty_flag_invert)
    && out_buf_empty)
    else $error("output empty flag not set at read end");
  a_full_update: assert property ((state_q == hpp_pkg::HPP_WRITE) && !wr_on
    && bsel_q |=> input_full_flag == ~$past(full_flag_invert) && in_buf_full)
    else $error("input full flag not set at write end");
  a_flag_polarity: assert property ($past(rst_n) |->
    output_empty_flag == (out_buf_empty ^ $past(empty_flag_invert))
    && input_full_flag == (in_buf_full ^ $past(full_flag_invert)))
    else $error("flag pin polarity mismatch");
  a_reset_flags: assert property (disable iff (1'b0) !rst_n |=>
    output_empty_flag && !input_full_flag && state_q == hpp_pkg::HPP_IDLE)
    else $error("flags not at empty levels after reset");
  a_status_read: assert property ((state_q == hpp_pkg::HPP_IDLE) && start_rd && stat_s
    |=> host_byte_bus_oe && host_byte_bus_out == $past(status_byte))
    else $error("status byte not returned");
  a_fields_held: assert property ((state_q != hpp_pkg::HPP_IDLE)
    && (state_q == $past(state_q)) |-> $stable(stat_q) && $stable(bsel_q))
    else $error("selects changed inside a transaction");
  a_low_half: assert property ((state_q == hpp_pkg::HPP_WRITE) && !wr_on && !bsel_q
    && !in_word_take |=> in_word[BW-1:0] == $past(data_s) && in_buf_full == $past(full_q))
    else $error("low half write misbehaved");

  c_word_read: cover property ((state_q == hpp_pkg::HPP_READ) && !rd_on && bsel_q && !stat_q);
  c_word_write: cover property ((state_q == hpp_pkg::HPP_WRITE) && !wr_on && bsel_q);
  c_status_read: cover property (start_rd && stat_s && (state_q == hpp_pkg::HPP_IDLE));
  c_single_write: cover property (mode_single_strobe && start_wr
    && (state_q == hpp_pkg::HPP_IDLE));
endmodule // hpp_port
`default_nettype wire

// File: rtl/hpp_pkg.sv
`default_nettype none
package hpp_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Longest flag update time after a transaction end, rounded down, at least one cycle
  localparam int unsigned FLAG_UPDATE_MAX_NS = 20;
  localparam int unsigned FLAG_UPDATE_CYC =
    (FLAG_UPDATE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (FLAG_UPDATE_MAX_NS / CLK_PERIOD_NS);
  // Least high or low time of chip select and strobes, rounded up
  localparam real PULSE_MIN_NS = 20.5;
  localparam int unsigned PULSE_MIN_CYC =
    int'($ceil(PULSE_MIN_NS / real'(CLK_PERIOD_NS)));
  // Status byte layout
  localparam int unsigned STAT_EMPTY_BIT = 0;
  localparam int unsigned STAT_FULL_BIT = 1;
  // Byte half select values; the high half completes a word
  localparam logic HALF_LOW = 1'b0;
  localparam logic HALF_HIGH = 1'b1;
  // Reset levels: output buffer empty, input buffer not full
  localparam logic EMPTY_RST = 1'b1;
  localparam logic FULL_RST = 1'b0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  // Synchroniser bundle: cs, rd, wr, ds, dir, stat, bsel, data
  localparam int unsigned SYNC_W = 7 + BYTE_W;
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h7000;
  typedef enum logic [1:0] {
    HPP_IDLE = 2'b00,
    HPP_READ = 2'b01,
    HPP_WRITE = 2'b10
  } hpp_state_e;
endpackage
`default_nettype wire

// File: rtl/hpp_sync.sv
`default_nettype none
module hpp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  // First stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      s1_d[i] = d[i];
      s2_d[i] = s1_q[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q = s2_q;
endmodule // hpp_sync
`default_nettype wire

// File: tb/hpp_host_model.sv
`default_nettype none
module hpp_host_model (
  input wire logic clk_sys, // System clock
  input wire logic [7:0] dev_data, // Device read byte
  input wire logic dev_oe, // Device drives bus
  output logic cs_n, // Chip select
  output logic rd_n, // Read strobe
  output logic wr_n, // Write strobe
  output logic ds, // Single data strobe
  output logic dir, // Direction, 1 = read
  output logic stat, // Status select
  output logic bsel, // Byte half select
  output logic [7:0] bus // Byte bus level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] idle_q = 8'h5A;
  // Undriven bus shows a changing pattern, never a held value
  always @(posedge clk_sys) idle_q <= ~idle_q;
  assign bus = dev_oe ? dev_data : (drv ? wd : idle_q);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ds = 1'b0;
    dir = 1'b1;
    stat = 1'b0;
    bsel = 1'b0;
  end
  task automatic edge1();
    @(posedge clk_sys);
    #5;
  endtask
  task automatic strobe(input logic on, input logic sgl, input logic hi, input logic rd);
    if (sgl) ds = on ~^ hi;
    else if (rd) rd_n = !on;
    else wr_n = !on;
  endtask
  task automatic xfer(input logic sgl, input logic hi, input logic rd, input logic st,
                      input logic hf, input logic csf, input logic sbe, input logic gl,
                      input logic [7:0] d, output logic [7:0] q);
    strobe(1'b0, sgl, hi, rd);
    dir = rd;
    stat = st;
    bsel = hf;
    wd = d;
    drv = !rd;
    edge1();
    if (csf) cs_n = 1'b0;
    else strobe(1'b1, sgl, hi, rd);
    repeat (2) edge1();
    if (csf) strobe(1'b1, sgl, hi, rd);
    else cs_n = 1'b0;
    repeat (3) edge1();
    if (gl) begin
      dir = !rd;
      stat = !st;
      bsel = !hf;
    end
    repeat (3) edge1();
    q = bus;
    if (sbe) strobe(1'b0, sgl, hi, rd);
    else cs_n = 1'b1;
    repeat (2) edge1();
    strobe(1'b0, sgl, hi, rd);
    cs_n = 1'b1;
    drv = 1'b0;
  endtask
endmodule // hpp_host_model
`default_nettype wire

// File: tb/test_parallel_host_port_handshake.sv
`default_nettype none
module test_parallel_host_port_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sgl, act_hi, inv_e, inv_f, ld, take, xe, xf;
  logic [15:0] ow, xo, xi;
  wire logic cs_n, rd_n, wr_n, ds, dir, st, bs, oe, fe, ff, ebuf, fbuf;
  wire logic [7:0] bus, bo;
  wire logic [15:0] iw;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 8894;
  always #25 clk_sys = ~clk_sys;
  hpp_host_model u_host (.clk_sys(clk_sys), .dev_data(bo), .dev_oe(oe), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .ds(ds), .dir(dir), .stat(st), .bsel(bs), .bus(bus));
  hpp_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .single_data_strobe(ds),
    .direction_read_write_n(dir), .status_select(st), .byte_half_select(bs),
    .host_byte_bus_in(bus), .host_byte_bus_out(bo), .host_byte_bus_oe(oe),
    .output_empty_flag(fe), .input_full_flag(ff), .mode_single_strobe(sgl),
    .strobe_active_high(act_hi), .empty_flag_invert(inv_e), .full_flag_invert(inv_f),
    .out_word_load(ld), .out_word(ow), .in_word_take(take), .in_word(iw),
    .out_buf_empty(ebuf), .in_buf_full(fbuf));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] exp_read(input logic so, input logic hf, input logic [15:0] w,
                                          input logic e, input logic f);
    return so ? {6'h00, f, e} : (hf ? w[15:8] : w[7:0]);
  endfunction
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk_sys);
    #5;
    s = 1'b0;
  endtask
  task automatic flags();
    repeat (3) @(posedge clk_sys);
    #5;
    check(ebuf, xe);
    check(fbuf, xf);
    check(fe, xe ^ inv_e);
    check(ff, xf ^ inv_f);
    check(iw, xi);
  endtask
  initial begin
    logic [7:0] q;
    logic [7:0] d;
    logic rd, so, hf, gl;
    {sgl, act_hi, inv_e, inv_f, ld, take} = 6'h0C;
    {ow, xo, xi, xe, xf} = {48'h0, 2'b10};
    repeat (3) @(posedge clk_sys);
    #5;
    check(fe, 1'b1);
    check(ff, 1'b0);
    check(oe, 1'b0);
    rst_n = 1'b1;
    for (int i = 0; i < 80; i++) begin
      if (i == 40) begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #5;
        check(fe, 1'b1);
        check(ff, 1'b0);
        check(ebuf, 1'b1);
        check(fbuf, 1'b0);
        check(iw, 16'h0000);
        rst_n = 1'b1;
        {xi, xe, xf} = {16'h0000, 2'b10};
      end
      {sgl, act_hi, inv_e, inv_f, rd, so, hf, gl} = 8'($random(seed));
      d = 8'($random(seed));
      if (i < 4) {sgl, act_hi, rd, so, hf, gl} = {i[1], i[0], i[0], 3'b010};
      if (rd && xe) begin
        ow = 16'($random(seed));
        pulse(ld);
        {xo, xe} = {ow, 1'b0};
      end
      if (!rd && xf) begin
        pulse(take);
        xf = 1'b0;
      end
      u_host.xfer(sgl, act_hi, rd, so, hf, d[0], d[1], gl, d, q);
      if (rd) begin
        check(q, exp_read(so, hf, xo, xe, xf));
        if (!so && hf) xe = 1'b1;
      end else begin
        if (hf) xi[15:8] = d;
        else xi[7:0] = d;
        if (hf) xf = 1'b1;
      end
      flags();
    end
    final_report();
  end
endmodule // test_parallel_host_port_handshake
`default_nettype wire
